// File: hdl/ovf_regs.vh
// Command codes, field positions, reset values and states of the over-voltage fault block
`ifndef OVF_REGS_VH
`define OVF_REGS_VH

// =====================================================================
// Command codes
`define OVF_CMD_TRIP_LEVEL 8'h55
`define OVF_CMD_REACTION 8'h56

// =====================================================================
// Reset values
`define OVF_TRIP_RESET 16'h7bff
`define OVF_REACT_RESET 8'h80

// =====================================================================
// Reaction register fields
`define OVF_MODE_HI 7
`define OVF_MODE_LO 6
`define OVF_RETRY_HI 5
`define OVF_RETRY_LO 3
`define OVF_DELAY_HI 2
`define OVF_DELAY_LO 0

// =====================================================================
// Field encodings
`define OVF_MODE_IGNORE 2'h0
`define OVF_MODE_DELAYED 2'h1
`define OVF_MODE_DISABLE 2'h2
`define OVF_MODE_RESUME 2'h3
`define OVF_RETRY_NONE 3'h0
`define OVF_RETRY_FOREVER 3'h7

// =====================================================================
// Linear format fields
`define OVF_LIN_EXP_HI 15
`define OVF_LIN_EXP_LO 11
`define OVF_LIN_MANT_HI 10
`define OVF_LIN_MANT_LO 0
`define OVF_LIN_BIAS 6'h10

// =====================================================================
// Reaction states
`define OVF_ST_RUN 3'h0
`define OVF_ST_GRACE 3'h1
`define OVF_ST_WAIT 3'h2
`define OVF_ST_HOLD 3'h3
`define OVF_ST_LATCH 3'h4
`define OVF_ST_OFF 3'h5

`endif

// File: hdl/ovf_input_overvolt_fault.v
// Input over-voltage trip level, reaction setting and fault reaction sequencer
`timescale 1ns/1ps
// How it works
// [R01] Trip level is a 16-bit linear-format value, compared in volts.
// [R02] Reaction 00: output keeps running through the fault.
// [R03] Reaction 01: run for the delay, then retry behaviour if fault remains.
// [R04] Reaction 10: disable output at once, then follow the retry count.
// [R05] Reaction 11: output off while fault present, back on when it clears.
// [R06] Retry code 000: no restart, output stays off until fault cleared.
// [R07] Codes 001-110: one to six restarts, then off until cleared.
// [R08] Attempt starts are spaced by the delay unit times two to the power of the delay field.
// [R09] Code 111: retry forever until commanded off or another fault.
// [R10] Delay field gives two to the power of the code in units.
// [R11] Size of a delay unit comes from a separate timing-unit input.
// [R12] Fault when measured input exceeds trip level; reported as status.
// [R13] Latched shutdown ends only on host fault clear or power cycle.
`include "ovf_regs.vh"

module ovf_input_overvolt_fault (
  input wire sys_clk_i,
  input wire rst_n_i,
  input wire cmd_wr_i,
  input wire cmd_rd_i,
  input wire [7:0] cmd_code_i,
  input wire [15:0] cmd_data_i,
  input wire [15:0] vin_meas_i,
  input wire [15:0] delay_unit_i,
  input wire fault_clear_i,
  input wire on_cmd_i,
  input wire other_fault_i,
  output reg [15:0] rd_data_o,
  output reg rd_ack_o,
  output reg cmd_err_o,
  output reg out_enable_o,
  output reg ov_fault_o,
  output reg ov_active_o,
  output reg [2:0] state_o
);

  // ===================================================================
  // Linear format to fixed point
  // Shift covers every exponent, so no two legal codes compare wrongly
  function [47:0] ovf_to_fixed;
    input [15:0] lin;
    reg [47:0] mant;
    reg [5:0] sh;
    begin
      mant = {{37{lin[`OVF_LIN_MANT_HI]}}, lin[`OVF_LIN_MANT_HI:`OVF_LIN_MANT_LO]};
      sh = {lin[`OVF_LIN_EXP_HI], lin[`OVF_LIN_EXP_HI:`OVF_LIN_EXP_LO]} + `OVF_LIN_BIAS;
      ovf_to_fixed = mant << sh;
    end
  endfunction

  // ===================================================================
  // Command registers
  reg [15:0] trip_level_r;
  reg [7:0] reaction_r;
  wire hit_trip = (cmd_code_i == `OVF_CMD_TRIP_LEVEL);
  wire hit_react = (cmd_code_i == `OVF_CMD_REACTION);

  always @(posedge sys_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      trip_level_r <= `OVF_TRIP_RESET;
      reaction_r <= `OVF_REACT_RESET;
      rd_data_o <= 16'h0000;
      rd_ack_o <= 1'b0;
      cmd_err_o <= 1'b0;
    end
    else
    begin
      if (cmd_wr_i && hit_trip)
        trip_level_r <= cmd_data_i; // [R01]
      if (cmd_wr_i && hit_react)
        reaction_r <= cmd_data_i[7:0];
      rd_ack_o <= cmd_rd_i;
      cmd_err_o <= (cmd_rd_i || cmd_wr_i) && !hit_trip && !hit_react;
      if (cmd_rd_i)
        rd_data_o <= hit_trip ? trip_level_r :
                     hit_react ? {8'h00, reaction_r} : 16'h0000;
    end
  end

  wire [1:0] mode = reaction_r[`OVF_MODE_HI:`OVF_MODE_LO];
  wire [2:0] retries = reaction_r[`OVF_RETRY_HI:`OVF_RETRY_LO];
  wire [2:0] delay_code = reaction_r[`OVF_DELAY_HI:`OVF_DELAY_LO];

  // ===================================================================
  // Fault detection
  // Signed compare of fixed-point values from both linear words
  wire ov_raw = $signed(ovf_to_fixed(vin_meas_i)) > $signed(ovf_to_fixed(trip_level_r)); // [R01]

  // ===================================================================
  // Delay length: unit times two to the code
  wire [22:0] delay_len = {7'h00, delay_unit_i} << delay_code; // [R10] [R11]

  // ===================================================================
  // Reaction sequencer
  // Binary state codes, also shown on the status port
  localparam [2:0] ST_RUN = `OVF_ST_RUN;
  localparam [2:0] ST_GRACE = `OVF_ST_GRACE;
  localparam [2:0] ST_WAIT = `OVF_ST_WAIT;
  localparam [2:0] ST_HOLD = `OVF_ST_HOLD;
  localparam [2:0] ST_LATCH = `OVF_ST_LATCH;
  localparam [2:0] ST_OFF = `OVF_ST_OFF;
  reg [2:0] state_r;
  reg [2:0] state_nxt;
  reg [22:0] cnt_r;
  reg [22:0] cnt_nxt;
  reg [2:0] left_r;
  reg [2:0] left_nxt;
  wire cnt_done = (cnt_r <= 23'h000001);
  // Latch unless tries remain; forever mode never runs out
  wire give_up = (retries != `OVF_RETRY_FOREVER) && (left_r == 3'h0);
  // Entering a wait spends one try, whichever path led there
  wire [2:0] first_left = (retries == `OVF_RETRY_FOREVER) ? retries : retries - 3'h1;

  always @*
  begin
    state_nxt = state_r;
    cnt_nxt = (cnt_r == 23'h000000) ? cnt_r : cnt_r - 23'h000001;
    left_nxt = left_r;
    case (state_r)
      ST_RUN:
      begin
        left_nxt = retries;
        if (ov_active_o)
        begin
          case (mode)
            `OVF_MODE_DELAYED:
            begin
              state_nxt = ST_GRACE; // [R03]
              cnt_nxt = delay_len;
            end
            `OVF_MODE_DISABLE:
            begin
              cnt_nxt = delay_len; // [R04]
              left_nxt = first_left; // [R07]
              state_nxt = (retries == `OVF_RETRY_NONE) ? ST_LATCH : ST_WAIT; // [R06]
            end
            `OVF_MODE_RESUME:
              state_nxt = ST_HOLD; // [R05]
            default:
              state_nxt = ST_RUN; // [R02]
          endcase
        end
      end
      ST_GRACE:
      begin
        if (!ov_active_o)
          state_nxt = ST_RUN;
        else if (cnt_done)
        begin
          cnt_nxt = delay_len; // [R03]
          left_nxt = first_left; // [R07]
          state_nxt = (retries == `OVF_RETRY_NONE) ? ST_LATCH : ST_WAIT;
        end
      end
      ST_WAIT:
      begin
        if (cnt_done)
        begin
          // Attempt fails if fault still there at its start
          if (!ov_active_o)
            state_nxt = ST_RUN; // [R08]
          else if (give_up)
            state_nxt = ST_LATCH; // [R07]
          else
          begin
            cnt_nxt = delay_len; // [R08] [R09]
            if (retries != `OVF_RETRY_FOREVER)
              left_nxt = left_r - 3'h1; // [R07]
          end
        end
      end
      ST_HOLD:
        if (!ov_active_o)
          state_nxt = ST_RUN; // [R05]
      ST_LATCH:
        if (fault_clear_i)
          state_nxt = ST_RUN; // [R13]
      ST_OFF:
        if (on_cmd_i && !other_fault_i)
          state_nxt = ST_RUN;
      default:
        state_nxt = ST_RUN;
    endcase
    // Commanded off or another shutdown ends any retry loop
    if ((!on_cmd_i || other_fault_i) && state_r != ST_LATCH)
      state_nxt = ST_OFF; // [R09]
  end

  // Status port mirrors the state register, so it needs no decode
  always @(posedge sys_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      state_r <= ST_OFF;
      cnt_r <= 23'h000000;
      left_r <= 3'h0;
      ov_active_o <= 1'b0;
      ov_fault_o <= 1'b0;
      out_enable_o <= 1'b0;
      state_o <= ST_OFF;
    end
    else
    begin
      state_r <= state_nxt;
      state_o <= state_nxt;
      cnt_r <= cnt_nxt;
      left_r <= left_nxt; // [R07]
      ov_active_o <= ov_raw; // [R12]
      // Set wins over a clear in the same cycle
      if (ov_raw)
        ov_fault_o <= 1'b1; // [R12]
      else if (fault_clear_i)
        ov_fault_o <= 1'b0; // [R13]
      out_enable_o <= (state_nxt == ST_RUN) || (state_nxt == ST_GRACE); // [R02] [R04]
    end
  end

endmodule // ovf_input_overvolt_fault

// File: dv/ovf_input_overvolt_fault_asserts.sv
// Checker for the over-voltage fault block
`timescale 1ns/1ps
// =====
// Checker
module ovf_input_overvolt_fault_asserts (
  input wire sys_clk_i,
  input wire rst_n_i,
  input wire cmd_wr_i,
  input wire cmd_rd_i,
  input wire [7:0] cmd_code_i,
  input wire [15:0] cmd_data_i,
  input wire fault_clear_i,
  input wire on_cmd_i,
  input wire other_fault_i,
  input wire rd_ack_o,
  input wire cmd_err_o,
  input wire out_enable_o,
  input wire ov_fault_o,
  input wire ov_active_o,
  input wire [2:0] state_o
);
  reg [7:0] react_r;
  wire [1:0] md = react_r[7:6];
  // Mode is only trusted while nothing else can move the state
  wire go = on_cmd_i && !other_fault_i && !cmd_wr_i && !fault_clear_i;
  wire hit = go && state_o == 3'h0 && ov_active_o;
  always @(posedge sys_clk_i or negedge rst_n_i)
    if (!rst_n_i)
      react_r <= 8'h80;
    else if (cmd_wr_i && cmd_code_i == 8'h56)
      react_r <= cmd_data_i[7:0];
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (!rst_n_i);
  AST_RD: assert property (cmd_rd_i |=> rd_ack_o)
    else $error("no read ack");
  AST_ERR: assert property ((cmd_rd_i || cmd_wr_i) && cmd_code_i != 8'h55
    && cmd_code_i != 8'h56 |=> cmd_err_o) else $error("no code error");
  AST_IGN: assert property (go && md == 2'h0 && state_o == 3'h0 |=> out_enable_o)
    else $error("ignore mode dropped output");
  AST_EN: assert property (out_enable_o == (state_o <= 3'h1))
    else $error("enable does not match state");
  AST_DIS: assert property (hit && md == 2'h2 |=> !out_enable_o)
    else $error("disable mode kept output");
  AST_HOLD: assert property (hit && md == 2'h3 |=> state_o == 3'h3)
    else $error("resume mode did not hold");
  AST_NORETRY: assert property (hit && md == 2'h2 && react_r[5:3] == 3'h0
    |=> state_o == 3'h4) else $error("no latch without retries");
  AST_OFF: assert property (!on_cmd_i && state_o != 3'h4 |=> state_o == 3'h5)
    else $error("off command ignored");
  AST_FLT: assert property (ov_active_o |-> ov_fault_o)
    else $error("fault status missing");
  AST_LATCH: assert property (state_o == 3'h4 && !fault_clear_i |=> state_o == 3'h4)
    else $error("latch left without clear");
  cover property (state_o == 3'h4);
  cover property (state_o == 3'h3);
  cover property (state_o == 3'h1);
endmodule // ovf_input_overvolt_fault_asserts

// File: dv/ovf_host_model.sv
// Host model driving the command port
`timescale 1ns/1ps
// =====
// Host
module ovf_host_model (
  input wire sys_clk_i,
  output reg cmd_wr_o,
  output reg cmd_rd_o,
  output reg [7:0] cmd_code_o,
  output reg [15:0] cmd_data_o,
  output reg fault_clear_o
);
  initial
  begin
    {cmd_wr_o, cmd_rd_o, fault_clear_o} = 3'h0;
    {cmd_code_o, cmd_data_o} = 24'h000000;
  end
  task xfer(input reg w, input reg [7:0] c, input reg [15:0] d);
  begin
    @(negedge sys_clk_i);
    {cmd_wr_o, cmd_rd_o, cmd_code_o, cmd_data_o} = {w, !w, c, d};
    @(negedge sys_clk_i);
    // Idle code and data lines never keep the old value
    {cmd_wr_o, cmd_rd_o, cmd_code_o, cmd_data_o} = {2'h0, ~c, ~d};
  end
  endtask
  task clear;
  begin
    @(negedge sys_clk_i);
    fault_clear_o = 1'b1;
    @(negedge sys_clk_i);
    fault_clear_o = 1'b0;
  end
  endtask
endmodule // ovf_host_model

// File: dv/ovf_input_overvolt_fault_test.sv
// Testbench for the over-voltage fault block
`timescale 1ns/1ps
// =====
// Bench
module ovf_input_overvolt_fault_test;
  reg clk = 1'b0;
  reg rst_n = 1'b0;
  reg on = 1'b1;
  reg oth = 1'b0;
  reg [15:0] vin = 16'h0032;
  reg [15:0] unit = 16'h0002;
  integer errors = 0;
  integer total_checks = 0;
  integer cyc = 0;
  integer n;
  wire wr, rd, clr;
  wire [7:0] code;
  wire [15:0] data;
  always #25 clk = ~clk;
  ovf_host_model h (.sys_clk_i(clk), .cmd_wr_o(wr), .cmd_rd_o(rd), .cmd_code_o(code),
    .cmd_data_o(data), .fault_clear_o(clr));
  ovf_input_overvolt_fault dut (.sys_clk_i(clk), .rst_n_i(rst_n), .cmd_wr_i(wr),
    .cmd_rd_i(rd), .cmd_code_i(code), .cmd_data_i(data), .vin_meas_i(vin),
    .delay_unit_i(unit), .fault_clear_i(clr), .on_cmd_i(on), .other_fault_i(oth),
    .rd_data_o(), .rd_ack_o(), .cmd_err_o(), .out_enable_o(), .ov_fault_o(), .ov_active_o(),
    .state_o());
  task chk(input [15:0] g, input [15:0] e);
  begin
    total_checks = total_checks + 1;
    if (g !== e)
    begin
      errors = errors + 1;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
    end
  end
  endtask
  task print_verdict;
  begin
    $display("checks=%0d errors=%0d", total_checks, errors);
    if (errors == 0 && total_checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  end
  endtask
  always @(posedge clk)
  begin
    cyc = cyc + 1;
    if (cyc == 3000)
    begin
      errors = errors + 1;
      print_verdict;
    end
  end
  // Cycles spent in state s, once it is entered
  task span(input [2:0] s);
  begin
    n = 0;
    while (dut.state_o !== s && n < 40)
    begin
      @(negedge clk);
      n = n + 1;
    end
    n = 0;
    while (dut.state_o === s && n < 300)
    begin
      @(negedge clk);
      n = n + 1;
    end
  end
  endtask
  task arm(input [7:0] r, input [15:0] u);
  begin
    unit = u;
    h.xfer(1'b1, 8'h56, {8'h00, r});
    vin = 16'h00c8;
  end
  endtask
  task calm;
  begin
    vin = 16'h0032;
    h.clear;
    repeat (3) @(negedge clk);
    chk(dut.out_enable_o, 16'h1);
  end
  endtask
  task t_regs;
  begin
    h.xfer(1'b0, 8'h55, 16'h0000);
    chk(dut.rd_data_o, 16'h7bff);
    chk(dut.rd_ack_o, 16'h1);
    chk(dut.out_enable_o, 16'h1);
    h.xfer(1'b0, 8'h56, 16'h0000);
    chk(dut.rd_data_o, 16'h0080);
    h.xfer(1'b0, 8'h10, 16'h0000);
    chk(dut.cmd_err_o, 16'h1);
    chk(dut.rd_data_o, 16'h0000);
    h.xfer(1'b1, 8'h55, 16'h0064);
    chk(dut.cmd_err_o, 16'h0);
    chk(dut.rd_ack_o, 16'h0);
    h.xfer(1'b0, 8'h55, 16'h0000);
    chk(dut.rd_data_o, 16'h0064);
    $display("regs done");
  end
  endtask
  task t_ignore;
  begin
    arm(8'h00, 16'h0002);
    repeat (6) @(negedge clk);
    chk({dut.out_enable_o, dut.ov_fault_o, dut.ov_active_o}, 16'h7);
    calm;
    chk(dut.ov_fault_o, 16'h0);
    $display("ignore done");
  end
  endtask
  // Two tries, each a wait of 2 units << code 1
  task t_retry;
  begin
    arm(8'h91, 16'h0002);
    span(3'h2);
    chk(n[15:0], 16'd8);
    chk(dut.out_enable_o, 16'h0);
    vin = 16'h0032;
    repeat (4) @(negedge clk);
    chk(dut.state_o, 16'h4);
    calm;
    $display("retry done");
  end
  endtask
  task t_grace;
  begin
    arm(8'h42, 16'h0003);
    span(3'h1);
    chk(n[15:0], 16'd12);
    chk(dut.state_o, 16'h4);
    calm;
    arm(8'h48, 16'h0003);
    repeat (3) @(negedge clk);
    chk(dut.out_enable_o, 16'h1);
    span(3'h2);
    chk(n[15:0], 16'd3);
    chk(dut.state_o, 16'h4);
    calm;
    $display("grace done");
  end
  endtask
  task t_resume;
  begin
    arm(8'hc0, 16'h0002);
    repeat (4) @(negedge clk);
    chk(dut.out_enable_o, 16'h0);
    vin = 16'h0032;
    repeat (4) @(negedge clk);
    chk(dut.out_enable_o, 16'h1);
    $display("resume done");
  end
  endtask
  task t_forever;
  begin
    arm(8'hb8, 16'h0002);
    repeat (60) @(negedge clk);
    chk(dut.state_o === 3'h4, 16'h0);
    chk(dut.state_o, 16'h2);
    on = 1'b0;
    repeat (2) @(negedge clk);
    chk(dut.state_o, 16'h5);
    chk(dut.out_enable_o, 16'h0);
    on = 1'b1;
    repeat (3) @(negedge clk);
    oth = 1'b1;
    repeat (2) @(negedge clk);
    chk(dut.state_o, 16'h5);
    oth = 1'b0;
    calm;
    $display("forever done");
  end
  endtask
  // Reset stands in for a power cycle ending a latched shutdown
  task t_latch;
  begin
    arm(8'h80, 16'h0002);
    repeat (4) @(negedge clk);
    chk(dut.state_o, 16'h4);
    vin = 16'h0032;
    repeat (4) @(negedge clk);
    chk(dut.out_enable_o, 16'h0);
    rst_n = 1'b0;
    repeat (2) @(negedge clk);
    chk(dut.state_o, 16'h5);
    rst_n = 1'b1;
    h.xfer(1'b0, 8'h55, 16'h0000);
    chk(dut.rd_data_o, 16'h7bff);
    chk(dut.out_enable_o, 16'h1);
    chk(dut.ov_fault_o, 16'h0);
    $display("latch done");
  end
  endtask
  initial
  begin
    repeat (4) @(negedge clk);
    rst_n = 1'b1;
    t_regs;
    t_ignore;
    t_retry;
    t_grace;
    t_resume;
    t_forever;
    t_latch;
    print_verdict;
  end
endmodule // ovf_input_overvolt_fault_test
bind ovf_input_overvolt_fault ovf_input_overvolt_fault_asserts u_ast (.sys_clk_i(sys_clk_i),
  .rst_n_i(rst_n_i), .cmd_wr_i(cmd_wr_i), .cmd_rd_i(cmd_rd_i), .cmd_code_i(cmd_code_i),
  .cmd_data_i(cmd_data_i), .fault_clear_i(fault_clear_i), .on_cmd_i(on_cmd_i),
  .other_fault_i(other_fault_i), .rd_ack_o(rd_ack_o), .cmd_err_o(cmd_err_o),
  .out_enable_o(out_enable_o), .ov_fault_o(ov_fault_o), .ov_active_o(ov_active_o),
  .state_o(state_o));
